// ==== sms_pkg.sv ====
// Purpose: Shared constants and carriers for the serial master/slave port
// Assumes: Wishbone classic slave with 32-bit data, word-aligned registers
// Notes: Register byte offsets and status layout are local choices
package sms_pkg;
  // Register byte offsets
  localparam logic [7:0] SMS_OFS_CTRL = 8'h00;
  localparam logic [7:0] SMS_OFS_STAT = 8'h04;
  localparam logic [7:0] SMS_OFS_BAUD = 8'h08;
  localparam logic [7:0] SMS_OFS_TXLO = 8'h0C;
  localparam logic [7:0] SMS_OFS_TXHI = 8'h10;
  localparam logic [7:0] SMS_OFS_RXD = 8'h14;
  // Control field positions
  localparam int SMS_CTL_ON = 15;
  localparam int SMS_CTL_GATE = 7;
  localparam int SMS_CTL_CTRLR = 5;
  localparam int SMS_CTL_DEEP = 0;
  // Status field positions
  localparam int SMS_ST_ROV = 6;
  localparam int SMS_ST_TBE = 3;
  localparam int SMS_ST_RXNE = 0;
  // Reset values, word width and FIFO depth
  localparam logic [15:0] SMS_CTRL_RST = 16'h0000;
  localparam logic [15:0] SMS_BAUD_RST = 16'h0000;
  localparam int SMS_WORD = 16;
  localparam int SMS_FIFO_DEPTH = 16;

  // Shift engine states
  typedef enum logic [1:0] {SMS_IDLE, SMS_SHIFT, SMS_DONE} sms_state_e;

  // Serial pin bundle seen by the block
  typedef struct packed {
    logic sck;
    logic sdi;
    logic sel_n;
  } sms_pins_s;
endpackage : sms_pkg

// ==== sms_fifo.sv ====
// Purpose: Receive word FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Full and empty are exact; a flush empties it in one cycle
`timescale 1ns/1ns
module sms_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sms_fifo depth must be a power of two");
  end

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and storage update
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : sms_fifo

// ==== sms_port.sv ====
// Purpose: Serial master/slave port with Wishbone register access
// Assumes: clk_i at 10 MHz; serial pins are asynchronous and synchronised here
// Notes: Mode 0 style: data out changes on falling clock, sampled on rising
//
// Overview of operation
// R1 - Master starts shifting out and in right after a transmit buffer write.
// R2 - Slave shifts only on clock edges from the external master.
// R3 - Clearing port_on stops the port and resets internal state.
// R4 - controller_select bit 5: one is master, zero is slave.
// R5 - deep_buffer_select bit 0: clear single buffering, set deep FIFO.
// R6 - Software clears receive_overflow_flag and empties receive buffer before enabling.
// R7 - Software flushes stale receive words before setting port_on.
// R8 - Software programs baud divider before enabling master operation.
// R9 - With select_pin_gate in slave mode, transfer only while select is low.
// R10 - Select high with gate releases serial_out_pin immediately, mid-word too.
// R11 - Aborted slave word restarts from bit one at next select fall.
// R12 - Without gate the select input has no effect in slave mode.
// R13 - Nothing else may drive the select pin when gating is used.
// R14 - Empty flag clears on write; sets on holding-to-shift move otherwise.
// R15 - Gated slave sets empty flag only after whole word is sent.
// R16 - One bit in per bit out; a word takes the same clocks both ways.
`timescale 1ns/1ns
module sms_port
  import sms_pkg::*;
#(
  parameter int WORD = sms_pkg::SMS_WORD,
  parameter int FIFO_DEPTH = sms_pkg::SMS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire sms_pkg::sms_pins_s pins_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  import sms_pkg::*;

  // The shift engine and buffers are built for 16-bit words only
  if (WORD != 16) begin : g_bad_word
    $error("sms_port supports 16-bit words only");
  end

  // Whole module state
  typedef struct packed {
    logic [2:0][2:0] sync;
    logic [15:0] ctrl;
    logic [15:0] baud;
    logic [15:0] txhold;
    logic tbe;
    logic rov;
    logic [15:0] shreg;
    logic [4:0] bitcnt;
    sms_state_e st;
    logic [15:0] divcnt;
    logic sck;
    logic sdo;
    logic sdo_oe;
    logic sck_oe;
    logic [2:0] last;
    logic ack;
    logic [31:0] rdat;
    logic rx_pop;
  } sms_state_s;

  sms_state_s q;
  sms_state_s next_q;

  // Receive FIFO wiring
  logic rx_push;
  logic rx_ready;
  logic rx_valid;
  logic [15:0] rx_word;
  logic rx_flush;

  // Word decode used for both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  wire logic bus_req = cyc_i && stb_i && !q.ack;
  wire logic wr = bus_req && we_i && sel_i[0];
  wire logic on = q.ctrl[SMS_CTL_ON];
  // R4 role select bit
  wire logic ctrlr = q.ctrl[SMS_CTL_CTRLR];
  wire logic gate = q.ctrl[SMS_CTL_GATE];
  wire logic deep = q.ctrl[SMS_CTL_DEEP];
  wire logic sck_s = q.sync[2][0];
  wire logic sdi_s = q.sync[2][1];
  wire logic sel_s = q.sync[2][2];
  wire logic sck_rise = sck_s && !q.last[0];
  wire logic sck_fall = !sck_s && q.last[0];
  wire logic sel_fall = !sel_s && q.last[2];
  // R12 select ignored ungated
  wire logic sel_ok = !gate || !sel_s;

  sms_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(rx_flush),
    .in_valid_i(rx_push),
    .in_data_i(q.shreg),
    .in_ready_o(rx_ready),
    .out_valid_o(rx_valid),
    .out_data_o(rx_word),
    .out_ready_i(q.rx_pop)
  );

  // R5 single buffer keeps one word
  wire logic rx_room = deep ? rx_ready : !rx_valid;
  assign rx_push = (q.st == SMS_DONE) && rx_room;
  // R3 disable also empties receive
  assign rx_flush = !on;

  // Next-state logic
  always_comb begin
    next_q = q;
    next_q.sync[0] = {pins_i.sel_n, pins_i.sdi, pins_i.sck};
    next_q.sync[1] = q.sync[0];
    next_q.sync[2] = q.sync[1];
    next_q.last = q.sync[2];
    next_q.rx_pop = 1'b0;
    next_q.ack = bus_req;
    // Register reads
    next_q.rdat = 32'h0000_0000;
    if (hit(adr_i, SMS_OFS_CTRL)) next_q.rdat[15:0] = q.ctrl;
    if (hit(adr_i, SMS_OFS_BAUD)) next_q.rdat[15:0] = q.baud;
    if (hit(adr_i, SMS_OFS_STAT)) begin
      next_q.rdat[SMS_ST_ROV] = q.rov;
      next_q.rdat[SMS_ST_TBE] = q.tbe;
      next_q.rdat[SMS_ST_RXNE] = rx_valid;
    end
    if (hit(adr_i, SMS_OFS_RXD)) begin
      next_q.rdat[15:0] = rx_valid ? rx_word : 16'h0000;
      next_q.rx_pop = bus_req && !we_i && rx_valid;
    end
    // Register writes
    if (wr && hit(adr_i, SMS_OFS_CTRL)) next_q.ctrl = dat_i[15:0];
    if (wr && hit(adr_i, SMS_OFS_BAUD)) next_q.baud = dat_i[15:0];
    if (wr && hit(adr_i, SMS_OFS_STAT) && dat_i[SMS_ST_ROV]) next_q.rov = 1'b0;
    if (wr && hit(adr_i, SMS_OFS_TXLO)) begin
      next_q.txhold[7:0] = dat_i[7:0];
    end
    // R14 write to buffer clears flag
    if (wr && hit(adr_i, SMS_OFS_TXHI)) begin
      next_q.txhold[15:8] = dat_i[7:0];
      next_q.tbe = 1'b0;
    end
    // Shift engine
    case (q.st)
      SMS_IDLE: begin
        next_q.sck = 1'b0;
        next_q.divcnt = '0;
        // R1 master starts on write
        if (on && ctrlr && !q.tbe) begin
          next_q.st = SMS_SHIFT;
          next_q.shreg = q.txhold;
          next_q.bitcnt = 5'd0;
          next_q.sdo = q.txhold[15];
          next_q.tbe = 1'b1;
        // R2 slave waits for external clock
        end else if (on && !ctrlr && !q.tbe && sel_ok) begin
          next_q.st = SMS_SHIFT;
          next_q.shreg = q.txhold;
          next_q.bitcnt = 5'd0;
          next_q.sdo = q.txhold[15];
          // R14 set on move ungated
          if (!gate) next_q.tbe = 1'b1;
        end
      end
      SMS_SHIFT: begin
        if (ctrlr) begin
          // R8 divider sets half period
          if (q.divcnt >= q.baud) begin
            next_q.divcnt = '0;
            next_q.sck = !q.sck;
            // R16 sample on rise, shift on fall
            if (!q.sck) begin
              next_q.shreg = {q.shreg[14:0], sdi_s};
              next_q.bitcnt = q.bitcnt + 5'd1;
            end else begin
              next_q.sdo = q.shreg[15];
              if (q.bitcnt == 5'd16) next_q.st = SMS_DONE;
            end
          end else begin
            next_q.divcnt = q.divcnt + 16'h0001;
          end
        end else if (gate && sel_s) begin
          // R11 abort, word kept for retry
          next_q.st = SMS_IDLE;
          next_q.tbe = 1'b0;
        end else begin
          // R16 one bit in per bit out
          if (sck_rise) begin
            next_q.shreg = {q.shreg[14:0], sdi_s};
            next_q.bitcnt = q.bitcnt + 5'd1;
            if (q.bitcnt == 5'd15) next_q.st = SMS_DONE;
          end
          if (sck_fall) next_q.sdo = q.shreg[15];
        end
      end
      SMS_DONE: begin
        next_q.st = SMS_IDLE;
        next_q.sck = 1'b0;
        if (!rx_room) next_q.rov = 1'b1;
        // R15 gated slave flags at end
        if (!ctrlr && gate) next_q.tbe = 1'b1;
      end
      default: next_q.st = SMS_IDLE;
    endcase
    // R11 retry waits for select fall
    if (!ctrlr && gate && q.st == SMS_IDLE && !sel_fall && !q.tbe && !q.sdo_oe) begin
      next_q.st = SMS_IDLE;
    end
    // Pin drivers
    next_q.sck_oe = on && ctrlr;
    // R9 R10 tri-state when deselected
    next_q.sdo_oe = on && (ctrlr || !gate || !sel_s);
    // R3 port off returns to reset
    if (!on) begin
      next_q.st = SMS_IDLE;
      next_q.sck = 1'b0;
      next_q.sdo = 1'b0;
      next_q.tbe = 1'b1;
      next_q.bitcnt = 5'd0;
      next_q.divcnt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= SMS_CTRL_RST;
      q.baud <= SMS_BAUD_RST;
      q.tbe <= 1'b1;
      q.st <= SMS_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flops
  assign dat_o = q.rdat;
  assign ack_o = q.ack;
  assign sck_o = q.sck;
  assign sck_oe_o = q.sck_oe;
  assign sdo_o = q.sdo;
  assign sdo_oe_o = q.sdo_oe;

  // Assertions
  property p_off_idle; // R3
    @(posedge clk_i) disable iff (rst_i) !on |=> q.st == SMS_IDLE && !sck_oe_o;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("port not idle when off"); // R3

  property p_tri; // R10
    @(posedge clk_i) disable iff (rst_i) (on && !ctrlr && gate && sel_s) |=> !sdo_oe_o;
  endproperty
  a_tri: assert property (p_tri) else $error("output driven while deselected"); // R10

  property p_abort; // R9
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_SHIFT && !ctrlr && gate && sel_s) |=> q.st == SMS_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("gated transfer not aborted"); // R9

  property p_slave_noclk; // R2
    @(posedge clk_i) disable iff (rst_i) !ctrlr |=> !sck_oe_o;
  endproperty
  a_slave_noclk: assert property (p_slave_noclk) else $error("slave drives clock"); // R2

  property p_start; // R1
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_IDLE && on && ctrlr && !q.tbe) |=> q.st == SMS_SHIFT && q.tbe;
  endproperty
  a_start: assert property (p_start) else $error("master did not start"); // R1

  property p_tbe_wr; // R14
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit(adr_i, SMS_OFS_TXHI) && on) |=> !q.tbe || q.st == SMS_SHIFT;
  endproperty
  a_tbe_wr: assert property (p_tbe_wr) else $error("empty flag not cleared"); // R14

  property p_gated_tbe; // R15
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_SHIFT && !ctrlr && gate && !q.tbe) |=> !q.tbe || $past(q.st) == SMS_DONE
        || !on || $past(wr);
  endproperty
  a_gated_tbe: assert property (p_gated_tbe) else $error("gated flag set early"); // R15

  property p_bits; // R16
    @(posedge clk_i) disable iff (rst_i) q.st == SMS_DONE |-> $past(q.bitcnt) >= 5'd15;
  endproperty
  a_bits: assert property (p_bits) else $error("word ended short"); // R16

  // Further guards on role, select gating, flags and bit timing
  property p_gate_wait;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_IDLE && on && !ctrlr && gate && sel_s) |=> q.st == SMS_IDLE;
  endproperty
  a_gate_wait: assert property (p_gate_wait) else $error("gated slave started unselected"); // R9

  property p_open_start;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_IDLE && on && !ctrlr && !gate && !q.tbe) |=> q.st == SMS_SHIFT && q.tbe;
  endproperty
  a_open_start: assert property (p_open_start) else $error("open slave did not load"); // R12

  property p_gated_hold;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_IDLE && on && !ctrlr && gate && !q.tbe) |=> !q.tbe;
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("gated flag set on load"); // R15

  property p_sdo_fall;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_SHIFT && on && ctrlr) |=> $stable(sdo_o) || $fell(sck_o);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("data moved off the falling edge"); // R16

  property p_off_flags;
    @(posedge clk_i) disable iff (rst_i)
      !on |=> q.tbe && !sdo_oe_o && !sdo_o;
  endproperty
  a_off_flags: assert property (p_off_flags) else $error("flags not reset when off"); // R3

  property p_single_ovf;
    @(posedge clk_i) disable iff (rst_i)
      (q.st == SMS_DONE && !deep && rx_valid) |=> q.rov;
  endproperty
  a_single_ovf: assert property (p_single_ovf) else $error("single buffer overflow missed"); // R5
endmodule : sms_port

// ==== sms_peer.sv ====
// Purpose: Far-side serial peer for the port bench
// Assumes: Mode 0, MSB first, 800 ns link clock
// Notes: Off frame the data line shows the inverse bit
`timescale 1ns/1ns
module sms_peer (
  // Line side
  input wire logic sck_line_i,
  input wire logic sdo_line_i,
  // Driven by the peer
  output logic sck_o,
  output logic sel_n_o,
  output logic sdi_o
);
  logic [15:0] tx = 16'h0000;
  logic [15:0] rx = 16'h0000;
  logic live = 1'b0;
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
  end
  // Never a stale copy outside a frame
  assign sdi_o = live ? tx[15] : ~tx[15];
  always @(posedge sck_line_i) rx <= {rx[14:0], sdo_line_i};
  always @(negedge sck_line_i) tx <= {tx[14:0], tx[15]};
  task load(input logic [15:0] w);
    tx = w;
    live = 1'b1;
  endtask : load
  // select and clock from peer only
  task run(input logic [15:0] w, input int bits, input logic sel);
    // Step off the clock edge so no pin moves while the port samples
    #25;
    load(w);
    sel_n_o = sel;
    #150;
    repeat (bits) begin
      #400 sck_o = 1'b1;
      #400 sck_o = 1'b0;
    end
    #150 sel_n_o = 1'b1;
    live = 1'b0;
  endtask : run
endmodule : sms_peer

// ==== spi_master_slave_port_tb_top.sv ====
// Purpose: Self-checking bench for sms_port
// Assumes: Wishbone classic, ack one cycle after request
// Notes: Peer makes the link clock only in slave mode
`timescale 1ns/1ns
module spi_master_slave_port_tb_top;
  import sms_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, q, dat_o;
  logic ack_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, p_sck, p_sel, p_sdi;
  sms_pins_s pins;
  int num_errors = 0, n_tests = 0, cyc_cnt = 0;
  // Wire levels from the enables
  assign pins = '{sck: sck_oe_o ? sck_o : p_sck, sdi: p_sdi, sel_n: p_sel};
  sms_port i_sms_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .pins_i(pins), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));
  // Released data line shows the inverse so a stale bit cannot pass
  sms_peer i_sms_peer (.sck_line_i(pins.sck), .sdo_line_i(sdo_oe_o ? sdo_o : ~sdo_o),
    .sck_o(p_sck), .sel_n_o(p_sel), .sdi_o(p_sdi));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Hang guard, far above the expected run
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      num_errors++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (t >= 20) chk("ack", 0, 1);
  endtask : wb
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(nm, q, e);
  endtask : rd
  task send(input logic [15:0] w);
    wb(1, SMS_OFS_TXLO, {24'h00_0000, w[7:0]});
    wb(1, SMS_OFS_TXHI, {24'h00_0000, w[15:8]});
  endtask : send
  task pop(input logic [15:0] e);
    int t;
    t = 0;
    q = 0;
    while (q[SMS_ST_RXNE] !== 1'b1 && t < 400) begin
      wb(0, SMS_OFS_STAT, 0);
      t++;
    end
    rd("rxd", SMS_OFS_RXD, {16'h0000, e});
  endtask : pop
  task t_reset;
    rd("ctrl", SMS_OFS_CTRL, 32'h0000_0000);
    rd("stat", SMS_OFS_STAT, 32'h0000_0008);
    rd("hole", 8'h1C, 32'h0000_0000);
    $display("reset done");
  endtask : t_reset
  task t_master;
    wb(1, SMS_OFS_BAUD, 32'h0000_0003);
    wb(1, SMS_OFS_STAT, 32'h0000_0040);
    wb(1, SMS_OFS_CTRL, 32'h0000_8020);
    i_sms_peer.load(16'h5AC3);
    send(16'h3CA5);
    pop(16'h5AC3);
    chk("peer", i_sms_peer.rx, 32'h0000_3CA5);
    rd("stat", SMS_OFS_STAT, 32'h0000_0008);
    $display("master done");
  endtask : t_master
  task t_gate;
    wb(1, SMS_OFS_CTRL, 32'h0000_0000);
    wb(1, SMS_OFS_CTRL, 32'h0000_8080);
    send(16'h1234);
    chk("oe", sdo_oe_o, 0);
    i_sms_peer.run(16'hC0DE, 5, 0);
    repeat (6) @(posedge clk_i);
    chk("oe", sdo_oe_o, 0);
    rd("stat", SMS_OFS_STAT, 32'h0000_0000);
    i_sms_peer.run(16'hC0DE, 16, 0);
    chk("peer", i_sms_peer.rx, 32'h0000_1234);
    pop(16'hC0DE);
    rd("stat", SMS_OFS_STAT, 32'h0000_0008);
    $display("gated slave done");
  endtask : t_gate
  task t_nogate;
    wb(1, SMS_OFS_CTRL, 32'h0000_8000);
    send(16'hBEEF);
    chk("sckoe", sck_oe_o, 0);
    i_sms_peer.run(16'h7E81, 16, 1);
    chk("peer", i_sms_peer.rx, 32'h0000_BEEF);
    pop(16'h7E81);
    $display("open slave done");
  endtask : t_nogate
  task t_off;
    wb(1, SMS_OFS_CTRL, 32'h0000_8020);
    send(16'h00FF);
    wb(1, SMS_OFS_CTRL, 32'h0000_0000);
    // Clock enable drops the cycle after the write lands
    @(posedge clk_i);
    chk("sckoe", sck_oe_o, 0);
    rd("stat", SMS_OFS_STAT, 32'h0000_0008);
    $display("stop done");
  endtask : t_off
  task fill(input logic [31:0] ctl, input int n, input int keep);
    int t;
    wb(1, SMS_OFS_STAT, 32'h0000_0040);
    wb(1, SMS_OFS_CTRL, ctl);
    for (int i = 0; i < n; i++) begin
      i_sms_peer.load({8'hC3, i[7:0]});
      send({8'h5A, i[7:0]});
      t = 0;
      while (i_sms_peer.rx !== {8'h5A, i[7:0]} && t < 2000) begin
        @(posedge clk_i);
        t++;
      end
      repeat (12) @(posedge clk_i);
    end
    rd("stat", SMS_OFS_STAT, 32'h0000_0049);
    for (int i = 0; i < keep; i++) pop({8'hC3, i[7:0]});
    rd("stat", SMS_OFS_STAT, 32'h0000_0048);
    wb(1, SMS_OFS_CTRL, 32'h0000_0000);
    $display("fill done");
  endtask : fill
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_master();
    t_gate();
    t_nogate();
    t_off();
    fill(32'h0000_8021, 17, 16);
    fill(32'h0000_8020, 2, 1);
    finish_test();
  end
endmodule : spi_master_slave_port_tb_top
